// [design/sasq_pkg.sv]
// package: register map, field layout and timing counts of the sequencer
package sasq_pkg;

	// register byte offsets on the APB bus
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_RESULT = 8'h04;
	localparam logic [7:0] OFS_CUT = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;

	// converter_mode_reg field positions
	localparam int BIT_SCAN_OR_SELECT = 0;
	localparam int BIT_CHANNEL_FIELD_BIT0 = 1;
	localparam int BIT_CHANNEL_FIELD_BIT2 = 3;
	localparam int BIT_SPEED_SELECT = 4;
	localparam int BIT_SCAN_SUBMODE = 5;
	localparam int BIT_EXT_TRIGGER_ENABLE = 6;
	localparam int BIT_RUN = 7;

	// status register field positions
	localparam int STS_BUSY = 0;
	localparam int STS_WAIT_TRIG = 1;
	localparam int STS_UNREAD = 2;
	localparam int STS_CH_LSB = 4;
	localparam int STS_CH_MSB = 6;

	// reset values
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] CUT_RESET = 8'h00;

	// first trial value of every conversion
	localparam logic [7:0] SAR_FIRST_TRIAL = 8'h80;

	// conversion and sampling times, in system clocks
	localparam int CONV_CLKS_SLOW = 180;
	localparam int SAMP_CLKS_SLOW = 36;
	localparam int CONV_CLKS_FAST = 120;
	localparam int SAMP_CLKS_FAST = 24;
	localparam int NUM_BITS = 8;

	// down-counter reloads derived from the times above
	localparam logic [7:0] SAMP_LOAD_SLOW = 8'(SAMP_CLKS_SLOW - 1);
	localparam logic [7:0] SAMP_LOAD_FAST = 8'(SAMP_CLKS_FAST - 1);
	localparam logic [7:0] STEP_LOAD_SLOW =
		8'((CONV_CLKS_SLOW - SAMP_CLKS_SLOW) / NUM_BITS - 1);
	localparam logic [7:0] STEP_LOAD_FAST =
		8'((CONV_CLKS_FAST - SAMP_CLKS_FAST) / NUM_BITS - 1);

	// sequencer states, gray along wait -> sample -> convert
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_SAMPLE = 2'b11,
		ST_CONV = 2'b10
	} sasq_state_t;

endpackage

// [design/sasq_top.sv]
// sar converter sequencer: mode control, binary search, result, apb slave
// Operation
// [R1] setting the run bit starts conversion with chosen channel and mode
// [R2] each conversion begins with approximation bit 7 set as trial
// [R3] trial bit stays one if comparator high, else cleared
// [R4] bits decided from msb down to lsb, one per step
// [R5] after eight bits the value is copied into the result register
// [R6] conversion-end interrupt raised in the same step as result store
// [R7] conversions repeat back to back while run stays set
// [R8] any mode write aborts conversion; run set restarts from first bit
// [R9] result register is not reset, undefined until first conversion
// [R10] conversion 180 clocks slow, 120 fast; sampling 36 or 24
// [R11] mode bit 0 picks scan or select; bit 5 picks scan submode
// [R12] select mode converts one named channel repeatedly, storing each result
// [R13] scan converts channel 0 up to field value, then wraps
// [R14] each scan conversion end stores result and raises interrupt
// [R15] scan mode 1: unread result makes next end restart silently
// [R16] scan mode 1 with result read behaves like scan mode 0
// [R17] software should prefer scan mode 1 for scanning
// [R18] software start: write mode with trigger enable clear, run set
// [R19] such a rewrite mid-conversion aborts and starts anew at once
// [R20] under software start the trigger pin has no influence
// [R21] current-cut register resets to zero, takes byte and bit writes; the code takes only whole-byte writes with strobe lane 0 set
// [R22] clearing run stops at once with no store and no interrupt
// [R23] trigger enable and run wait for edge; further edge restarts
// [R24] trial code drives tap selector; comparator sampled once per step
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps

module sasq_top
(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analog front end
	input wire logic comparator_in,
	output logic [7:0] tap_code,
	output logic [2:0] channel_sel,
	output logic sample_hold,
	output logic comparator_power,
	output logic [7:0] current_cut,
	// trigger and event
	input wire logic ext_trigger_pin,
	output logic conversion_end_irq
);

	// decide one trial bit from the comparator answer
	function automatic logic [7:0] decide_bit(input logic [7:0] approximation_reg,
		input logic [2:0] idx, input logic comp);
		logic [7:0] r;
		r = approximation_reg;
		if (!comp)
		begin
			r[idx] = 1'b0;
		end
		return r;
	endfunction

	// first channel of a conversion sequence for a given mode value
	function automatic logic [2:0] first_channel(input logic [7:0] mode);
		logic [2:0] r;
		r = 3'h0;
		if (mode[sasq_pkg::BIT_SCAN_OR_SELECT])
		begin
			r = mode[sasq_pkg::BIT_CHANNEL_FIELD_BIT2:
				sasq_pkg::BIT_CHANNEL_FIELD_BIT0];
		end
		return r;
	endfunction

	// reset release through two flip-flops
	logic rst_meta_q;
	logic rst_n;
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// three-stage synchronisers for trigger pin and comparator
	logic [2:0] trg_sync_q;
	logic [2:0] trg_sync_d;
	logic [2:0] cmp_sync_q;
	logic [2:0] cmp_sync_d;
	logic trg_lvl_q;
	logic trg_lvl_d;
	logic cmp_lvl_q;
	logic cmp_lvl_d;
	logic trig_edge;
	always_comb
	begin
		trg_sync_d = {trg_sync_q[1:0], ext_trigger_pin};
		cmp_sync_d = {cmp_sync_q[1:0], comparator_in};
		trg_lvl_d = trg_lvl_q;
		cmp_lvl_d = cmp_lvl_q;
		if (trg_sync_q[1] == trg_sync_q[2])
		begin
			trg_lvl_d = trg_sync_q[2];
		end
		if (cmp_sync_q[1] == cmp_sync_q[2])
		begin
			cmp_lvl_d = cmp_sync_q[2];
		end
	end
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trg_sync_q <= 3'h0;
			cmp_sync_q <= 3'h0;
			trg_lvl_q <= 1'b0;
			cmp_lvl_q <= 1'b0;
		end
		else
		begin
			trg_sync_q <= trg_sync_d;
			cmp_sync_q <= cmp_sync_d;
			trg_lvl_q <= trg_lvl_d;
			cmp_lvl_q <= cmp_lvl_d;
		end
	end
	// valid edge: rising edge of the filtered trigger level
	assign trig_edge = trg_lvl_d & ~trg_lvl_q;

	// apb decode
	logic acc;
	logic setup;
	logic mapped;
	logic wr_mode;
	logic wr_cut;
	logic rd_result;
	always_comb
	begin
		acc = psel & penable;
		setup = psel & ~penable;
		mapped = (paddr == sasq_pkg::OFS_MODE) |
			(paddr == sasq_pkg::OFS_RESULT) |
			(paddr == sasq_pkg::OFS_CUT) |
			(paddr == sasq_pkg::OFS_STATUS);
		wr_mode = acc & pwrite & pstrb[0] & (paddr == sasq_pkg::OFS_MODE);
		wr_cut = acc & pwrite & pstrb[0] & (paddr == sasq_pkg::OFS_CUT);
		rd_result = acc & ~pwrite & (paddr == sasq_pkg::OFS_RESULT);
	end
	// zero wait states; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;

	// sequencer and register state
	sasq_pkg::sasq_state_t state_q;
	sasq_pkg::sasq_state_t state_d;
	logic [7:0] mode_q;
	logic [7:0] mode_d;
	logic [7:0] cut_q;
	logic [7:0] cut_d;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic [2:0] bit_q;
	logic [2:0] bit_d;
	logic [7:0] sar_q;
	logic [7:0] sar_d;
	logic [2:0] ch_q;
	logic [2:0] ch_d;
	logic unread_q;
	logic unread_d;
	logic irq_q;
	logic irq_d;
	logic [7:0] res_q;
	logic [7:0] res_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic [7:0] sar_dec;
	logic [7:0] samp_load;
	logic [7:0] step_load;
	logic store;
	logic scan;
	logic start;

	// next-state logic for the conversion sequence
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		bit_d = bit_q;
		sar_d = sar_q;
		ch_d = ch_q;
		res_d = res_q;
		irq_d = 1'b0;
		store = 1'b0;
		start = 1'b0;
		cut_d = cut_q;
		mode_d = mode_q;
		if (wr_mode)
		begin
			mode_d = pwdata[7:0];
		end
		if (wr_cut)
		begin
			cut_d = pwdata[7:0]; // [R21]
		end
		// speed bit picks the timing set
		if (mode_d[sasq_pkg::BIT_SPEED_SELECT])
		begin
			samp_load = sasq_pkg::SAMP_LOAD_FAST; // [R10]
			step_load = sasq_pkg::STEP_LOAD_FAST; // [R10]
		end
		else
		begin
			samp_load = sasq_pkg::SAMP_LOAD_SLOW; // [R10]
			step_load = sasq_pkg::STEP_LOAD_SLOW; // [R10]
		end
		// setting both scan-select and submode is treated as select
		scan = ~mode_q[sasq_pkg::BIT_SCAN_OR_SELECT]; // [R11]
		sar_dec = decide_bit(sar_q, bit_q, cmp_lvl_q); // [R3] [R24]
		unique case (state_q)
			sasq_pkg::ST_IDLE:
			begin
			end
			sasq_pkg::ST_WAIT:
			begin
				start = trig_edge; // [R23]
			end
			sasq_pkg::ST_SAMPLE:
			begin
				if (cnt_q == 8'h00)
				begin
					state_d = sasq_pkg::ST_CONV;
					cnt_d = step_load;
					bit_d = 3'h7;
				end
				else
				begin
					cnt_d = cnt_q - 8'h01;
				end
			end
			sasq_pkg::ST_CONV:
			begin
				if (cnt_q != 8'h00)
				begin
					cnt_d = cnt_q - 8'h01;
				end
				else if (bit_q != 3'h0)
				begin
					// keep decided bit, set next lower trial bit
					sar_d = sar_dec | (8'h01 << (bit_q - 3'h1)); // [R4]
					bit_d = bit_q - 3'h1; // [R4]
					cnt_d = step_load;
				end
				else
				begin
					// all eight bits decided; unread stall in scan mode 1
					store = ~(scan & mode_q[sasq_pkg::BIT_SCAN_SUBMODE] &
						unread_q); // [R15] [R16]
					if (store)
					begin
						res_d = sar_dec; // [R5] [R12] [R14]
						irq_d = 1'b1; // [R6]
						if (scan)
						begin
							// advance and wrap at the field value
							if (ch_q == mode_q[sasq_pkg::BIT_CHANNEL_FIELD_BIT2:
								sasq_pkg::BIT_CHANNEL_FIELD_BIT0])
							begin
								ch_d = 3'h0; // [R13]
							end
							else
							begin
								ch_d = ch_q + 3'h1; // [R13]
							end
						end
					end
					// next conversion follows at once
					state_d = sasq_pkg::ST_SAMPLE; // [R7]
					cnt_d = samp_load;
					sar_d = sasq_pkg::SAR_FIRST_TRIAL; // [R2]
				end
			end
		endcase
		// trigger edge restarts only while hardware start is armed
		if (state_q != sasq_pkg::ST_IDLE && state_q != sasq_pkg::ST_WAIT &&
			mode_q[sasq_pkg::BIT_EXT_TRIGGER_ENABLE] &&
			mode_q[sasq_pkg::BIT_RUN]) // [R20]
		begin
			start = trig_edge; // [R23]
		end
		// a mode write overrides everything in progress
		if (wr_mode)
		begin
			store = 1'b0; // [R22]
			irq_d = 1'b0; // [R22]
			res_d = res_q; // [R8]
			if (!mode_d[sasq_pkg::BIT_RUN])
			begin
				state_d = sasq_pkg::ST_IDLE; // [R22]
				start = 1'b0;
			end
			else if (mode_d[sasq_pkg::BIT_EXT_TRIGGER_ENABLE])
			begin
				state_d = sasq_pkg::ST_WAIT; // [R23]
				start = 1'b0;
			end
			else
			begin
				start = 1'b1; // [R1] [R8] [R18] [R19]
			end
		end
		// begin a fresh conversion from the first channel and bit
		if (start)
		begin
			state_d = sasq_pkg::ST_SAMPLE;
			cnt_d = samp_load;
			sar_d = sasq_pkg::SAR_FIRST_TRIAL; // [R2]
			ch_d = first_channel(mode_d); // [R1] [R12] [R13]
			store = 1'b0;
			irq_d = 1'b0;
			res_d = res_q;
		end
	end

	// unread flag: a new store wins over a read in the same cycle
	always_comb
	begin
		unread_d = unread_q;
		// a store at the setup edge means the read returned older data
		if (rd_result && !irq_q)
		begin
			unread_d = 1'b0; // [R16]
		end
		if (store)
		begin
			unread_d = 1'b1; // [R15]
		end
	end

	// read data captured in the setup phase
	always_comb
	begin
		prdata_d = prdata_q;
		if (setup)
		begin
			prdata_d = 32'h0000_0000;
			unique case (paddr)
				sasq_pkg::OFS_MODE: prdata_d[7:0] = mode_q;
				sasq_pkg::OFS_RESULT: prdata_d[7:0] = res_q;
				sasq_pkg::OFS_CUT: prdata_d[7:0] = cut_q;
				sasq_pkg::OFS_STATUS:
				begin
					prdata_d[sasq_pkg::STS_BUSY] =
						state_q[1];
					prdata_d[sasq_pkg::STS_WAIT_TRIG] =
						(state_q == sasq_pkg::ST_WAIT);
					prdata_d[sasq_pkg::STS_UNREAD] = unread_q;
					prdata_d[sasq_pkg::STS_CH_MSB:sasq_pkg::STS_CH_LSB] = ch_q;
				end
				default: prdata_d = 32'h0000_0000;
			endcase
		end
	end

	// registered control state
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= sasq_pkg::ST_IDLE;
			mode_q <= sasq_pkg::MODE_RESET;
			cut_q <= sasq_pkg::CUT_RESET; // [R21]
			cnt_q <= 8'h00;
			bit_q <= 3'h7;
			sar_q <= sasq_pkg::SAR_FIRST_TRIAL;
			ch_q <= 3'h0;
			unread_q <= 1'b0;
			irq_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			state_q <= state_d;
			mode_q <= mode_d;
			cut_q <= cut_d;
			cnt_q <= cnt_d;
			bit_q <= bit_d;
			sar_q <= sar_d;
			ch_q <= ch_d;
			unread_q <= unread_d;
			irq_q <= irq_d;
			prdata_q <= prdata_d;
		end
	end

	// result register carries no reset
	always_ff @(posedge clock)
	begin
		res_q <= res_d; // [R9]
	end

	// outputs
	assign prdata = prdata_q;
	assign conversion_end_irq = irq_q; // [R6]
	assign tap_code = sar_q; // [R24]
	assign channel_sel = ch_q;
	assign sample_hold = (state_q == sasq_pkg::ST_SAMPLE);
	assign comparator_power = mode_q[sasq_pkg::BIT_RUN]; // [R22]
	assign current_cut = cut_q;

endmodule // sasq_top

// [testbench/sasq_chk_sva.sv]
// checker: timing and register relations at the sequencer ports
`timescale 1ns/1ps
module sasq_chk
(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	// converter side
	input wire logic [7:0] tap_code,
	input wire logic sample_hold,
	input wire logic comparator_power,
	input wire logic [7:0] current_cut,
	input wire logic ext_trigger_pin,
	input wire logic conversion_end_irq
);
	localparam int CF = sasq_pkg::CONV_CLKS_FAST;
	localparam int CS = sasq_pkg::CONV_CLKS_SLOW;
	logic wm, wc, fast_q, fast_d, cv_q, cv_d, so_q, so_d;
	logic [15:0] cc_q, cc_d, sc_q, sc_d;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	// register writes taken at the access edge
	assign wm = psel && penable && pwrite && pstrb[0] && paddr == 8'h00;
	assign wc = psel && penable && pwrite && pstrb[0] && paddr == 8'h08;
	// speed bit, cycles since last event, cycles spent sampling
	always_comb
	begin
		fast_d = wm ? pwdata[sasq_pkg::BIT_SPEED_SELECT] : fast_q;
		cc_d = conversion_end_irq ? 16'h0001 : cc_q + 16'h0001;
		cv_d = !wm && !ext_trigger_pin && (conversion_end_irq || cv_q);
		sc_d = sample_hold ? sc_q + 16'h0001 : 16'h0000;
		so_d = sample_hold ? so_q && !wm && !ext_trigger_pin : 1'b1;
	end
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			fast_q <= 1'b0;
			cc_q <= 16'h0000;
			cv_q <= 1'b0;
			sc_q <= 16'h0000;
			so_q <= 1'b1;
		end
		else
		begin
			fast_q <= fast_d;
			cc_q <= cc_d;
			cv_q <= cv_d;
			sc_q <= sc_d;
			so_q <= so_d;
		end
	end
	// a trial code is held for at least eight cycles of a step unless a restart cuts it
	sequence tap_hold;
		($stable(tap_code) || sample_hold || !comparator_power)[*8];
	endsequence
	AST_TAP_STEP: assert property ($changed(tap_code) && !sample_hold |=>
		tap_hold)
		else $error("trial code changed within a step");
	AST_FIRST_TRIAL: assert property (sample_hold |-> tap_code == 8'h80)
		else $error("first trial code wrong while sampling");
	AST_SAMP_LEN: assert property ($fell(sample_hold) && so_q |->
		sc_q == (fast_q ? 16'h0018 : 16'h0024))
		else $error("sampling length wrong");
	AST_CONV_LEN: assert property (conversion_end_irq && cv_q |->
		cc_q % (fast_q ? CF : CS) == 0)
		else $error("conversion length wrong");
	AST_IRQ_PULSE: assert property (conversion_end_irq |=>
		!conversion_end_irq)
		else $error("end event longer than one cycle");
	AST_STOPPED: assert property (!comparator_power |->
		!sample_hold && !conversion_end_irq)
		else $error("activity while stopped");
	AST_RUN_WR: assert property (wm |=>
		comparator_power == $past(pwdata[7]))
		else $error("run bit not taken from mode write");
	AST_CUT_WR: assert property (wc |=>
		current_cut == $past(pwdata[7:0]))
		else $error("current cut write not taken");
endmodule // sasq_chk

// [testbench/sasq_cmp_model.sv]
// model: comparator behind the tap string, one level per channel
`timescale 1ns/1ps
module sasq_cmp_model
(
	// clock
	input wire logic clock,
	// from the sequencer
	input wire logic power,
	input wire logic [7:0] tap_code,
	input wire logic [2:0] channel_sel,
	// channel c level in bits 8c+7:8c
	input wire logic [63:0] levels,
	// to the sequencer
	output logic comparator_in
);
	logic junk_q = 1'b0;
	// an unpowered comparator gives no usable answer
	always @(posedge clock)
		junk_q <= ~junk_q;
	// high when the selected input is at or above the tap
	assign comparator_in = power ?
		levels[8 * channel_sel +: 8] >= tap_code : junk_q;
endmodule // sasq_cmp_model

// [testbench/tb.sv]
// testbench: sequencer driven over apb against the comparator model
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] AM = sasq_pkg::OFS_MODE;
	localparam logic [7:0] AR = sasq_pkg::OFS_RESULT;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'hF;
	logic trig = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, cmp, irq, smp, pwr;
	logic [7:0] tap, cut, rd;
	logic err;
	logic [2:0] ch;
	logic [63:0] lvl = 64'hF0D2B496785A3C1E;
	int mismatches = 0;
	int total_checks = 0;
	int k;
	// 10 MHz system clock
	always #50 clock = ~clock;
	sasq_top dut_u
	(
		.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.comparator_in(cmp), .tap_code(tap), .channel_sel(ch),
		.sample_hold(smp), .comparator_power(pwr), .current_cut(cut),
		.ext_trigger_pin(trig), .conversion_end_irq(irq)
	);
	sasq_cmp_model cmp_u
	(
		.clock(clock), .power(pwr), .tap_code(tap), .channel_sel(ch),
		.levels(lvl), .comparator_in(cmp)
	);
	// verdict and end of run
	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	// one transfer, held until pready is seen high at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s);
		int i;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		pstrb <= s;
		@(posedge clock);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge clock);
			if (pready === 1'b1)
				break;
		end
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20)
		begin
			mismatches++;
			stop_test();
		end
	endtask
	// count end events over n cycles, optionally leaving at the first
	task irqs(input int n, input logic first);
		k = 0;
		repeat (n)
		begin
			@(negedge clock);
			if (irq === 1'b1)
				k++;
			if (first && k > 0)
				break;
		end
	endtask
	// next event must come within 400 cycles, then read result
	task next_res(input logic [7:0] exp);
		irqs(400, 1'b1);
		if (k == 0)
		begin
			mismatches++;
			stop_test();
		end
		apb(1'b0, AR, 8'h00, 4'hF);
		chk(rd, exp);
	endtask
	initial
	begin
		repeat (4) @(posedge clock);
		nrst <= 1'b1;
		repeat (3) @(posedge clock);
		// reset values, then a dropped write with lane 0 off
		chk(cut, 8'h00);
		apb(1'b0, AM, 8'h00, 4'hF);
		chk(rd, sasq_pkg::MODE_RESET);
		apb(1'b1, sasq_pkg::OFS_CUT, 8'hA5, 4'hF);
		apb(1'b1, sasq_pkg::OFS_CUT, 8'h5A, 4'h0);
		apb(1'b0, sasq_pkg::OFS_CUT, 8'h00, 4'hF);
		chk(rd, 8'hA5);
		// unmapped address answers with an error and zero data
		apb(1'b0, 8'h10, 8'h00, 4'hF);
		chk(8'(err), 8'h01);
		chk(rd, 8'h00);
		// select channel 3, slow then fast, repeated results
		for (int f = 0; f < 2; f++)
		begin
			apb(1'b1, AM, f ? 8'h97 : 8'h87, 4'hF);
			repeat (2)
				next_res(lvl[31:24]);
		end
		// scan mode 0 over channels 0 and 1 wraps back
		apb(1'b1, AM, 8'h82, 4'hF);
		for (int i = 0; i < 3; i++)
			next_res(lvl[8 * (i % 2) +: 8]);
		// scan mode 1: an unread result stalls the scan silently
		apb(1'b1, AM, 8'hA4, 4'hF);
		next_res(lvl[7:0]);
		irqs(500, 1'b0);
		chk(8'(k), 8'h01);
		// stalled on channel 2: busy, unread, channel held
		apb(1'b0, sasq_pkg::OFS_STATUS, 8'h00, 4'hF);
		chk(rd, 8'h25);
		chk(8'(ch), 8'h02);
		apb(1'b0, AR, 8'h00, 4'hF);
		chk(rd, lvl[15:8]);
		next_res(lvl[23:16]);
		// rewrite mid conversion restarts on the new channel
		apb(1'b1, AM, 8'h83, 4'hF);
		repeat (100) @(posedge clock);
		apb(1'b1, AM, 8'h85, 4'hF);
		irqs(150, 1'b1);
		chk(8'(k), 8'h00);
		next_res(lvl[23:16]);
		// clearing run mid conversion gives no result and no event
		repeat (100) @(posedge clock);
		apb(1'b1, AM, 8'h05, 4'hF);
		irqs(300, 1'b0);
		chk(8'(k), 8'h00);
		// trigger enabled: idle until a rising edge on the pin
		apb(1'b1, AM, 8'hC3, 4'hF);
		irqs(300, 1'b0);
		chk(8'(k), 8'h00);
		@(posedge clock);
		trig <= 1'b1;
		next_res(lvl[15:8]);
		stop_test();
	end
endmodule // tb
bind sasq_top sasq_chk chk_u
(
	.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.tap_code(tap_code), .sample_hold(sample_hold),
	.comparator_power(comparator_power), .current_cut(current_cut),
	.ext_trigger_pin(ext_trigger_pin),
	.conversion_end_irq(conversion_end_irq)
);
